// file: gas_valve_pkg.sv
// Constants and types for the gas valve process-data block
package gas_valve_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int CAL_TIME_MS = 15000;
   localparam int LOCK_TIME_MS = 150;
   localparam int CAL_CYCLES = CAL_TIME_MS * (CLK_HZ / 1000);
   localparam int LOCK_CYCLES = LOCK_TIME_MS * (CLK_HZ / 1000);
   // Select word fields
   localparam int SEL_GAS2 = 0;
   localparam int SEL_GAS1 = 1;
   localparam int SEL_GAS3 = 2;
   localparam int SEL_CAL = 3;
   // Status word fields
   localparam int STA_REACHED = 0;
   localparam int STA_READY = 1;
   localparam int STA_WARN = 2;
   localparam int STA_ERROR = 3;
   localparam int STA_CAL = 4;
   // Pressure figures (offset in mbar, the rest in percent of target) and word limits
   localparam logic [15:0] REACHED_OFFSET_MBAR = 16'h00D2;
   localparam logic [15:0] REACHED_PCT = 16'h0004;
   localparam logic [15:0] WARN_PCT = 16'h006E;
   localparam logic [15:0] ERROR_PCT = 16'h0069;
   localparam logic [7:0] TOL_MAX = 8'hAA;
   localparam logic [15:0] SERIAL_MIN = 16'h0001;
   localparam logic [15:0] SERIAL_MAX = 16'h270F;
   localparam logic [15:0] LOOP_MAX = 16'h2710;
   localparam logic [15:0] SPARE_VALUE = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [2:0] GAS_NONE = 3'h0;
   // Arbitrary revision value
   localparam logic [15:0] REVISION_DEFAULT = 16'h0100;
   typedef enum logic [1:0] {
      ST_CAL,
      ST_RUN,
      ST_LOCK
   } mode_e;
endpackage

// file: gas_valve_process_data.sv
// Process-data word bank of the gas valve with calibration and gas interlock
module gas_valve_process_data
   import gas_valve_pkg::*;
#(
   parameter int CAL_COUNT = CAL_CYCLES,
   parameter int LOCK_COUNT = LOCK_CYCLES,
   parameter logic [15:0] SERIAL = SERIAL_MIN,
   parameter logic [15:0] REVISION = REVISION_DEFAULT
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [15:0] target_pressure,
   input wire logic [15:0] gas_select_control,
   input wire logic [15:0] tolerance_window,
   input wire logic [15:0] sensor_outlet,
   input wire logic [15:0] sensor_inlet,
   input wire logic [15:0] loop_output,
   output logic [15:0] actual_pressure,
   output logic [15:0] inlet_pressure,
   output logic [15:0] loop_set_value,
   output logic [15:0] unit_serial,
   output logic [15:0] firmware_revision,
   output logic [15:0] spare_word_a,
   output logic [15:0] spare_word_b,
   output logic [15:0] spare_word_c,
   output logic [15:0] tolerance_readback,
   output logic [15:0] valve_status,
   output logic [2:0] gas_valve_on
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers: process words come from the fieldbus and sensor side

   // Words are sampled bit by bit: a word moving on a sampling edge may show
   // a mix of old and new bits for one cycle, so the master holds words steady
   logic [15:0] sel_meta;
   logic [15:0] sel_sync;
   logic [15:0] tgt_meta;
   logic [15:0] tgt;
   logic [15:0] tol_meta;
   logic [15:0] tol_sync;
   logic [15:0] out_meta;
   logic [15:0] outlet;
   logic [15:0] in_meta;
   logic [15:0] inlet;
   logic [15:0] loop_meta;
   logic [15:0] loop_sync;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sel_meta <= 16'h0000;
         sel_sync <= 16'h0000;
      end else begin
         sel_meta <= gas_select_control;
         sel_sync <= sel_meta;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tgt_meta <= 16'h0000;
         tgt <= 16'h0000;
      end else begin
         tgt_meta <= target_pressure;
         tgt <= tgt_meta;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tol_meta <= 16'h0000;
         tol_sync <= 16'h0000;
      end else begin
         tol_meta <= tolerance_window;
         tol_sync <= tol_meta;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         out_meta <= 16'h0000;
         outlet <= 16'h0000;
      end else begin
         out_meta <= sensor_outlet;
         outlet <= out_meta;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         in_meta <= 16'h0000;
         inlet <= 16'h0000;
      end else begin
         in_meta <= sensor_inlet;
         inlet <= in_meta;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         loop_meta <= 16'h0000;
         loop_sync <= 16'h0000;
      end else begin
         loop_meta <= loop_output;
         loop_sync <= loop_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Percent of target in mbar, truncated; 32-bit product avoids overflow
   function automatic logic [31:0] pct_of(input logic [15:0] value, input logic [15:0] pct);
      logic [31:0] prod;
      prod = 32'(value) * 32'(pct);
      return prod / 32'd100;
   endfunction

   function automatic logic [7:0] clamp_tol(input logic [7:0] b);
      return (b > TOL_MAX) ? TOL_MAX : b;
   endfunction

   function automatic logic at_most_one(input logic [2:0] v);
      return (v & (v - 3'h1)) == 3'h0;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Mode sequencer: power-on calibration, run, post-switch-off lockout

   mode_e mode;
   // One timer serves calibration and lockout; the two never overlap
   logic [31:0] timer;
   logic cal_req_d;
   logic [2:0] gas_req;
   logic one_hot_ok;
   logic cal_rise;

   assign gas_req = {sel_sync[SEL_GAS3], sel_sync[SEL_GAS1], sel_sync[SEL_GAS2]};
   assign one_hot_ok = at_most_one(gas_req);
   // Edge, not level: a request left high must not restart calibration
   assign cal_rise = sel_sync[SEL_CAL] && !cal_req_d;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cal_req_d <= 1'b0;
      end else begin
         cal_req_d <= sel_sync[SEL_CAL];
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mode <= ST_CAL;
         timer <= 32'h0;
         gas_valve_on <= GAS_NONE;
      end else begin
         case (mode)
            ST_CAL: begin
               gas_valve_on <= GAS_NONE;
               if (timer >= 32'(CAL_COUNT - 1)) begin
                  mode <= ST_RUN;
                  timer <= 32'h0;
               end else begin
                  timer <= timer + 32'h1;
               end
            end
            ST_RUN: begin
               if (cal_rise) begin
                  // Calibration during run closes gases and restarts the timer
                  mode <= ST_CAL;
                  timer <= 32'h0;
                  gas_valve_on <= GAS_NONE;
               end else if ((gas_valve_on & ~gas_req) != 3'h0) begin
                  mode <= ST_LOCK;
                  timer <= 32'h0;
                  gas_valve_on <= gas_valve_on & gas_req;
               end else if (one_hot_ok) begin
                  gas_valve_on <= gas_req;
               end
            end
            ST_LOCK: begin
               // Inputs ignored here; a calibration rise during lockout is lost
               if (timer >= 32'(LOCK_COUNT - 1)) begin
                  mode <= ST_RUN;
                  timer <= 32'h0;
               end else begin
                  timer <= timer + 32'h1;
               end
            end
            default: begin
               mode <= ST_CAL;
               timer <= 32'h0;
               gas_valve_on <= GAS_NONE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pressure comparisons

   logic reached;
   logic warn;
   logic err;
   logic [31:0] band;
   logic [31:0] diff;

   always_comb begin
      band = pct_of(tgt, REACHED_PCT) + 32'(REACHED_OFFSET_MBAR);
      diff = (outlet >= tgt) ? 32'(outlet - tgt) : 32'(tgt - outlet);
      reached = diff < band;
      warn = 32'(inlet) < pct_of(tgt, WARN_PCT);
      err = 32'(inlet) < pct_of(tgt, ERROR_PCT);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output words, all registered

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         valve_status <= STATUS_RESET;
      end else begin
         valve_status <= 16'h0000;
         valve_status[STA_REACHED] <= reached && mode != ST_CAL;
         valve_status[STA_READY] <= mode != ST_CAL;
         valve_status[STA_WARN] <= warn;
         valve_status[STA_ERROR] <= err;
         valve_status[STA_CAL] <= mode == ST_CAL;
      end
   end

   // One register per word keeps each word's reset and source together
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         actual_pressure <= 16'h0000;
      end else begin
         actual_pressure <= outlet;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         inlet_pressure <= 16'h0000;
      end else begin
         inlet_pressure <= inlet;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         loop_set_value <= 16'h0000;
      end else begin
         loop_set_value <= (loop_sync > LOOP_MAX) ? LOOP_MAX : loop_sync;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tolerance_readback <= 16'h0000;
      end else begin
         tolerance_readback <= {clamp_tol(tol_sync[15:8]), clamp_tol(tol_sync[7:0])};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         unit_serial <= SERIAL_MIN;
      end else begin
         // Out-of-range strap falls back to the lowest legal number
         unit_serial <= (SERIAL >= SERIAL_MIN && SERIAL <= SERIAL_MAX) ? SERIAL : SERIAL_MIN;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         firmware_revision <= 16'h0000;
      end else begin
         firmware_revision <= REVISION;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         spare_word_a <= SPARE_VALUE;
      end else begin
         spare_word_a <= SPARE_VALUE;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         spare_word_b <= SPARE_VALUE;
      end else begin
         spare_word_b <= SPARE_VALUE;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         spare_word_c <= SPARE_VALUE;
      end else begin
         spare_word_c <= SPARE_VALUE;
      end
   end

endmodule // gas_valve_process_data

// file: gas_valve_process_data_bench.sv
// Self-checking bench for the gas valve process-data block
module gas_valve_process_data_bench import gas_valve_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CAL = 50;
   localparam int LOCK = 20;
   localparam logic [15:0] SER = 16'h04D2;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] target_pressure, gas_select_control, tolerance_window, sensor_outlet, sensor_inlet, loop_output;
   logic [15:0] actual_pressure, inlet_pressure, loop_set_value, unit_serial, firmware_revision;
   logic [15:0] spare_word_a, spare_word_b, spare_word_c, tolerance_readback, valve_status;
   logic [2:0] gas_valve_on;
   logic [31:0] rnd = 32'hBE50;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;
   always #5 clk_sys = ~clk_sys;
   // Arbitrary revision value
   gas_valve_process_data #(.CAL_COUNT(CAL), .LOCK_COUNT(LOCK), .SERIAL(SER), .REVISION(16'h0203))
      gas_valve_process_data_i (.clk_sys(clk_sys), .nrst(nrst), .target_pressure(target_pressure),
      .gas_select_control(gas_select_control), .tolerance_window(tolerance_window),
      .sensor_outlet(sensor_outlet), .sensor_inlet(sensor_inlet), .loop_output(loop_output),
      .actual_pressure(actual_pressure), .inlet_pressure(inlet_pressure), .loop_set_value(loop_set_value),
      .unit_serial(unit_serial), .firmware_revision(firmware_revision), .spare_word_a(spare_word_a),
      .spare_word_b(spare_word_b), .spare_word_c(spare_word_c), .tolerance_readback(tolerance_readback),
      .valve_status(valve_status), .gas_valve_on(gas_valve_on));
   machine_master #(.LOCK_COUNT(LOCK)) machine_master_i (.clk_sys(clk_sys), .valve_status(valve_status),
      .target_pressure(target_pressure), .gas_select_control(gas_select_control));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] clamp(input logic [7:0] b);
      return (b > 8'hAA) ? 8'hAA : b;
   endfunction
   function automatic logic [15:0] exp_sta(input logic [31:0] t, o, i);
      logic [31:0] d;
      d = (o > t) ? o - t : t - o;
      return {12'h000, i < t * 32'h69 / 32'h64, i < t * 32'h6E / 32'h64, 1'b1, d < t * 32'h4 / 32'h64 + 32'hD2};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      {tolerance_window, sensor_outlet, sensor_inlet, loop_output} = '0;
      repeat (20) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (CAL + 10) @(negedge clk_sys);
      chk(valve_status, exp_sta(0, 0, 0));
      chk(unit_serial, SER);
      chk(firmware_revision, 16'h0203);
      chk(spare_word_a | spare_word_b | spare_word_c, 16'h0000);
      // Outlet sits on the reached limit or one below it
      for (int k = 0; k < 12; k++) begin
         rnd = nxt(rnd);
         machine_master_i.put(16'h0000, 16'(rnd % 30001));
         sensor_outlet = 16'(32'(target_pressure) * 4 / 100 + 210 + target_pressure - k % 2);
         sensor_inlet = 16'(target_pressure + target_pressure * rnd[20:16] / 100);
         loop_output = rnd[31:16];
         tolerance_window = rnd[31:16] ^ rnd[15:0];
         repeat (6) @(negedge clk_sys);
         chk(actual_pressure, sensor_outlet);
         chk(inlet_pressure, sensor_inlet);
         chk(loop_set_value, (loop_output > 16'h2710) ? 16'h2710 : loop_output);
         chk(tolerance_readback, {clamp(tolerance_window[15:8]), clamp(tolerance_window[7:0])});
         chk(valve_status, exp_sta(target_pressure, sensor_outlet, sensor_inlet));
      end
      for (int g = 0; g < 3; g++) begin
         machine_master_i.change_gas(16'(1 << g), 16'h0BB8);
         repeat (6) @(negedge clk_sys);
         chk(16'(gas_valve_on), 16'(1 << g));
      end
      machine_master_i.change_gas(16'h0003, 16'h0000);
      repeat (6) @(negedge clk_sys);
      chk(16'(gas_valve_on), 16'h0000);
      machine_master_i.put(16'h0002, 16'h0000);
      repeat (6) @(negedge clk_sys);
      machine_master_i.put(16'h0000, 16'h0000);
      repeat (4) @(negedge clk_sys);
      machine_master_i.put(16'h0004, 16'h0000);
      repeat (6) @(negedge clk_sys);
      chk(16'(gas_valve_on), 16'h0000);
      repeat (LOCK) @(negedge clk_sys);
      chk(16'(gas_valve_on), 16'h0004);
      machine_master_i.change_gas(16'h0008, 16'h0000);
      for (n = 0; n < 10 && valve_status[4] !== 1'b1; n++) @(negedge clk_sys);
      chk(valve_status & 16'h0012, 16'h0010);
      for (n = 0; n < CAL + 20 && valve_status[1] !== 1'b1; n++) @(negedge clk_sys);
      chk(16'(n > CAL - 3 && n < CAL + 4), 16'h0001);
      end_sim();
   end
endmodule // gas_valve_process_data_bench
bind gas_valve_process_data gas_valve_process_data_sva #(.CAL_COUNT(CAL_COUNT), .LOCK_COUNT(LOCK_COUNT))
   gas_valve_process_data_sva_i (.clk_sys(clk_sys), .nrst(nrst), .target_pressure(target_pressure),
   .gas_select_control(gas_select_control), .sensor_outlet(sensor_outlet), .sensor_inlet(sensor_inlet),
   .valve_status(valve_status), .gas_valve_on(gas_valve_on));

// file: gas_valve_process_data_sva.sv
// Checker on the gas valve process-data ports
module gas_valve_process_data_sva
   import gas_valve_pkg::*;
#(parameter int CAL_COUNT = 50, parameter int LOCK_COUNT = 20) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [15:0] target_pressure,
   input wire logic [15:0] gas_select_control,
   input wire logic [15:0] sensor_outlet,
   input wire logic [15:0] sensor_inlet,
   input wire logic [15:0] valve_status,
   input wire logic [2:0] gas_valve_on
);
   localparam int CAL_LO = CAL_COUNT - 2;
   localparam int CAL_HI = CAL_COUNT + 3;
   logic [7:0] quiet;
   logic [31:0] dif;
   assign dif = 32'((sensor_outlet > target_pressure) ? sensor_outlet - target_pressure : target_pressure - sensor_outlet);
   // Cycles with every valve closed, saturating
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst)
         quiet <= 8'h00;
      else if (gas_valve_on != 3'h0)
         quiet <= 8'h00;
      else if (quiet != 8'hFF)
         quiet <= quiet + 8'h01;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////
   chk_reserved_bits: assert property (valve_status[15:5] == 11'h000)
      else $error("reserved status bits set");
   chk_one_gas: assert property ($onehot0(gas_valve_on))
      else $error("more than one gas on");
   chk_cal_flags: assert property (valve_status[4] |-> !valve_status[1] && gas_valve_on == 3'h0)
      else $error("ready or gas during calibration");
   chk_cal_start: assert property ($rose(gas_select_control[3]) && valve_status[1] && quiet > 8'(LOCK_COUNT + 2) |-> ##[3:5] valve_status[4])
      else $error("calibration not started");
   chk_cal_length: assert property ($rose(valve_status[4]) |-> ##[CAL_LO:CAL_HI] ($fell(valve_status[4]) && valve_status[1]))
      else $error("calibration length wrong");
   chk_gas_warn: assert property (($stable(target_pressure) && $stable(sensor_inlet)) [*5] |-> valve_status[3:2] == {32'(sensor_inlet) < 32'(target_pressure) * 32'h69 / 32'h64, 32'(sensor_inlet) < 32'(target_pressure) * 32'h6E / 32'h64})
      else $error("supply flags wrong");
   chk_reached: assert property (($stable(target_pressure) && $stable(sensor_outlet) && valve_status[1]) [*5] |-> valve_status[0] == (dif < 32'(target_pressure) * 32'h4 / 32'h64 + 32'hD2))
      else $error("reached flag wrong");
   chk_gas_select: assert property (($stable(gas_select_control) && valve_status[1]) [*5] ##0 ($onehot(gas_select_control[2:0]) && quiet > 8'h28) |-> gas_valve_on == gas_select_control[2:0])
      else $error("selected gas not on");
   chk_lockout: assert property (quiet != 8'h00 && quiet < 8'(LOCK_COUNT - 2) |-> gas_valve_on == 3'h0)
      else $error("gas on inside lockout");
   cov_cal_done: cover property ($fell(valve_status[4]));
   cov_gas3: cover property ($rose(gas_valve_on[2]));
   cov_reached: cover property (valve_status[0] && target_pressure != 16'h0000);
endmodule // gas_valve_process_data_sva

// file: machine_master.sv
// Model of the machine controller writing the command words
module machine_master #(parameter int LOCK_COUNT = 20) (
   input wire logic clk_sys,
   input wire logic [15:0] valve_status,
   output logic [15:0] target_pressure,
   output logic [15:0] gas_select_control
);
   initial begin
      target_pressure = 16'h0000;
      gas_select_control = 16'h0000;
   end
   // Drop the request once the device shows it was taken
   always @(negedge clk_sys) begin
      if (gas_select_control[3] && (!valve_status[1] || valve_status[4])) begin
         gas_select_control[3] <= 1'b0;
      end
   end
   task automatic put(input logic [15:0] sel, input logic [15:0] tgt);
      @(negedge clk_sys);
      gas_select_control = sel;
      target_pressure = tgt;
   endtask
   // Lockout wait avoids losing the new request
   task automatic change_gas(input logic [15:0] sel, input logic [15:0] tgt);
      put(16'h0000, 16'h0000);
      repeat (LOCK_COUNT + 10) @(negedge clk_sys);
      put(sel, tgt);
   endtask
endmodule // machine_master
